// File: logic/ptc_timer.sv
// Purpose: control of a 10-bit periodic timer behind an apb slave
// Assumes: compare events arrive as one-cycle inputs; the capture pin is a level, edge detected here
// Notes: comparators live outside; this block acts on their match
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - 10-bit period in low and high registers
// - pause holds counter, release resumes
// - clock select picks counter clock source
// - run rising clears counter and starts
// - run cleared stops counter, keeps value
// - run rising restores output initial level in compare and pwm modes
// - control zero low three bits read zero
// - mode field picks compare/capture/pwm/timer
// - timer mode does not drive pin
// - compare match: none, low, high, toggle
// - pwm: inactive, active, single pulse for both 10 and 11
// - capture edge select latches counter
// - output level bit: initial or active level
module ptc_timer (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // clock sources and capture input
  input wire logic i_sub_tick,
  input wire logic i_ext_clock_pin,
  input wire logic i_capture_pin,
  // comparator events
  input wire logic i_match_a,
  input wire logic i_match_p,
  // timer pin and state
  output logic o_timer_out,
  output logic o_timer_oe,
  output logic [9:0] o_count,
  output logic o_capture_pulse
);
  ////////////////////////////////////////////////////////////////////////
  // register state and internal strobes
  logic [7:0] period_low;
  logic [1:0] period_high;
  logic [7:0] timer_control_zero;
  logic [7:0] timer_control_one;
  logic [1:0] capture_clear_sel;
  logic [9:0] capture_reg_a;
  logic capture_seen;
  logic [9:0] count;
  logic run_prev;
  logic capt_prev;
  logic pulse_done;
  logic count_tick;
  logic wr_en;
  logic rd_en;
  logic run_rise;
  logic cap_trig;
  logic cap_take;
  logic pwm_active;
  logic [31:0] next_prdata;

  // field views of the control bytes
  wire logic pause_ctl = timer_control_zero[ptc_pkg::C0_PAUSE];
  wire logic run_ctl = timer_control_zero[ptc_pkg::C0_RUN];
  wire logic [2:0] clock_sel = timer_control_zero[ptc_pkg::C0_CLK_HI:ptc_pkg::C0_CLK_LO];
  wire logic [1:0] op_mode_sel = timer_control_one[ptc_pkg::C1_MODE_HI:ptc_pkg::C1_MODE_LO];
  wire logic [1:0] pin_function_sel = timer_control_one[ptc_pkg::C1_PIN_HI:ptc_pkg::C1_PIN_LO];
  wire logic output_init_level = timer_control_one[ptc_pkg::C1_OINIT];

  // address match, used by both read and write paths
  function automatic logic hit(input logic [7:0] addr, input logic [7:0] reg_addr);
    hit = (addr == reg_addr);
  endfunction

  // modes that own the timer pin
  function automatic logic drives_pin(input logic [1:0] mode);
    drives_pin = (mode != ptc_pkg::MODE_TMR);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // apb: zero wait states, writes land at the access edge
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign rd_en = i_psel & ~i_pwrite;

  // period low byte
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      period_low <= ptc_pkg::RESET_BYTE;
    end else if (wr_en && hit(i_paddr, ptc_pkg::ADDR_PERIOD_LOW)) begin
      period_low <= i_pwdata[7:0];
    end
  end

  // only the two top period bits exist in the high register
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      period_high <= ptc_pkg::RESET_BYTE[1:0];
    end else if (wr_en && hit(i_paddr, ptc_pkg::ADDR_PERIOD_HIGH)) begin
      period_high <= i_pwdata[1:0];
    end
  end

  // control zero; low bits are never stored
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_control_zero <= ptc_pkg::RESET_BYTE;
    end else if (wr_en && hit(i_paddr, ptc_pkg::ADDR_CTRL_ZERO)) begin
      timer_control_zero <= i_pwdata[7:0] & ptc_pkg::C0_WMASK;
    end
  end

  // mode taken as written; keeping it stable while on is software's job
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      timer_control_one <= ptc_pkg::RESET_BYTE;
    end else if (wr_en && hit(i_paddr, ptc_pkg::ADDR_CTRL_ONE)) begin
      timer_control_one <= i_pwdata[7:0];
    end
  end

  // capture clear setting; only 00 lets a capture through
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capture_clear_sel <= ptc_pkg::RESET_BYTE[1:0];
    end else if (wr_en && hit(i_paddr, ptc_pkg::ADDR_CAPT_CFG)) begin
      capture_clear_sel <= i_pwdata[1:0];
    end
  end

  // read mux, registered for the access phase
  always_comb begin
    next_prdata = 32'h0000_0000;
    if (hit(i_paddr, ptc_pkg::ADDR_PERIOD_LOW)) begin
      next_prdata[7:0] = period_low;
    end else if (hit(i_paddr, ptc_pkg::ADDR_PERIOD_HIGH)) begin
      next_prdata[1:0] = period_high;
    end else if (hit(i_paddr, ptc_pkg::ADDR_CTRL_ZERO)) begin
      next_prdata[7:0] = timer_control_zero & ptc_pkg::C0_WMASK;
    end else if (hit(i_paddr, ptc_pkg::ADDR_CTRL_ONE)) begin
      next_prdata[7:0] = timer_control_one;
    end else if (hit(i_paddr, ptc_pkg::ADDR_CAPT_STAT)) begin
      next_prdata[9:0] = capture_reg_a;
      next_prdata[16] = capture_seen;
    end else if (hit(i_paddr, ptc_pkg::ADDR_CAPT_CFG)) begin
      next_prdata[1:0] = capture_clear_sel;
    end else if (hit(i_paddr, ptc_pkg::ADDR_CMP_A)) begin
      next_prdata[9:0] = count;
    end
  end

  // setup cycle loads read data, unmapped reads give zero
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h0000_0000;
    end else if (rd_en & ~i_penable) begin
      o_prdata <= next_prdata;
    end
  end

  // always ready: no wait states, so no access can stall the bus
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
    end else begin
      o_pready <= 1'b1;
    end
  end

  // never an error; unmapped addresses simply read zero
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pslverr <= 1'b0;
    end else begin
      o_pslverr <= ptc_pkg::PSLVERR_OK[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // counter clock source
  ptc_clock_gen u_clock_gen (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_sub_tick(i_sub_tick),
    .i_ext_clock_pin(i_ext_clock_pin),
    .i_clock_sel(clock_sel),
    .o_count_tick(count_tick)
  );

  // edge of run bit
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      run_prev <= 1'b0;
    end else begin
      run_prev <= run_ctl;
    end
  end
  assign run_rise = run_ctl & ~run_prev;

  // counter: clear on switch on, hold on pause or off, else count
  // a switch-on clears even while paused, so software sees a fresh start
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      count <= ptc_pkg::RESET_CNT;
    end else if (run_rise) begin
      count <= ptc_pkg::RESET_CNT;
    end else if (!run_ctl || pause_ctl) begin
      count <= count;
    end else if (count_tick) begin
      count <= count + 10'h001;
    end
  end

  // registered copy keeps the count output straight from a flop
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count <= ptc_pkg::RESET_CNT;
    end else begin
      o_count <= count;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // capture input edge select
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capt_prev <= 1'b0;
    end else begin
      capt_prev <= i_capture_pin;
    end
  end

  // trigger edge decode; 11 never fires
  always_comb begin
    case (pin_function_sel)
      ptc_pkg::PIN_00: cap_trig = i_capture_pin & ~capt_prev;
      ptc_pkg::PIN_01: cap_trig = ~i_capture_pin & capt_prev;
      ptc_pkg::PIN_10: cap_trig = i_capture_pin ^ capt_prev;
      default: cap_trig = 1'b0;
    endcase
  end

  // capture only when on, in capture mode, with clear setting 00
  assign cap_take = run_ctl && (op_mode_sel == ptc_pkg::MODE_CAPT) &&
                    (capture_clear_sel == 2'h0) && cap_trig;

  // capture register holds the count seen at the trigger
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capture_reg_a <= ptc_pkg::RESET_CNT;
    end else if (cap_take) begin
      capture_reg_a <= count;
    end
  end

  // seen flag: a new capture wins over the read that clears it
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      capture_seen <= 1'b0;
    end else if (cap_take) begin
      capture_seen <= 1'b1;
    end else if (rd_en && i_penable && hit(i_paddr, ptc_pkg::ADDR_CAPT_STAT)) begin
      capture_seen <= 1'b0;
    end
  end

  // one-cycle pulse for each capture
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_capture_pulse <= 1'b0;
    end else begin
      o_capture_pulse <= cap_take;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pwm level: active from switch on until i_match_a; i_match_p sets it again only before the first i_match_a
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pwm_active <= 1'b0;
      pulse_done <= 1'b0;
    end else if (run_rise) begin
      pwm_active <= 1'b1;
      pulse_done <= 1'b0;
    end else if (i_match_a) begin
      pwm_active <= 1'b0;
      pulse_done <= 1'b1;
    end else if (i_match_p && !pulse_done) begin
      pwm_active <= 1'b1;
    end
  end

  // pin enable: timer mode leaves the pin alone
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_oe <= 1'b0;
    end else begin
      o_timer_oe <= drives_pin(op_mode_sel);
    end
  end

  // output pin level per mode
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_timer_out <= 1'b0;
    end else begin
      case (op_mode_sel)
        ptc_pkg::MODE_CMP: begin
          if (run_rise) begin
            o_timer_out <= output_init_level;
          end else if (run_ctl && i_match_a) begin
            case (pin_function_sel)
              ptc_pkg::PIN_01: o_timer_out <= 1'b0;
              ptc_pkg::PIN_10: o_timer_out <= 1'b1;
              ptc_pkg::PIN_11: o_timer_out <= ~o_timer_out;
              default: o_timer_out <= o_timer_out;
            endcase
          end
        end
        ptc_pkg::MODE_PWM: begin
          if (run_rise) begin
            o_timer_out <= output_init_level;
          end else begin
            // active level follows the output level bit
            case (pin_function_sel)
              ptc_pkg::PIN_00: o_timer_out <= ~output_init_level;
              ptc_pkg::PIN_01: o_timer_out <= output_init_level;
              ptc_pkg::PIN_10: o_timer_out <= pwm_active ~^ output_init_level;
              ptc_pkg::PIN_11: o_timer_out <= (pwm_active & ~pulse_done) ~^ output_init_level;
              default: o_timer_out <= o_timer_out;
            endcase
          end
        end
        default: o_timer_out <= o_timer_out; // capture and timer leave it
      endcase
    end
  end
endmodule
`default_nettype wire

// File: logic/ptc_pkg.sv
// Purpose: shared constants for the periodic timer control block
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: offsets below are byte addresses
package ptc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_PERIOD_LOW = 8'h00;
  localparam logic [7:0] ADDR_PERIOD_HIGH = 8'h04;
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'h08;
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h0c;
  localparam logic [7:0] ADDR_CAPT_STAT = 8'h10;
  localparam logic [7:0] ADDR_CAPT_CFG = 8'h14;
  localparam logic [7:0] ADDR_CMP_A = 8'h18;
  // control zero fields
  localparam int C0_PAUSE = 7;
  localparam int C0_CLK_HI = 6;
  localparam int C0_CLK_LO = 4;
  localparam int C0_RUN = 3;
  localparam logic [7:0] C0_WMASK = 8'hf8;
  // control one fields
  localparam int C1_MODE_HI = 7;
  localparam int C1_MODE_LO = 6;
  localparam int C1_PIN_HI = 5;
  localparam int C1_PIN_LO = 4;
  localparam int C1_OINIT = 3;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [9:0] RESET_CNT = 10'h000;
  // operating modes
  localparam logic [1:0] MODE_CMP = 2'h0;
  localparam logic [1:0] MODE_CAPT = 2'h1;
  localparam logic [1:0] MODE_PWM = 2'h2;
  localparam logic [1:0] MODE_TMR = 2'h3;
  // pin function codes
  localparam logic [1:0] PIN_00 = 2'h0;
  localparam logic [1:0] PIN_01 = 2'h1;
  localparam logic [1:0] PIN_10 = 2'h2;
  localparam logic [1:0] PIN_11 = 2'h3;
  // clock select codes
  localparam logic [2:0] CK_SYS4 = 3'h0;
  localparam logic [2:0] CK_SYS = 3'h1;
  localparam logic [2:0] CK_H16 = 3'h2;
  localparam logic [2:0] CK_H64 = 3'h3;
  localparam logic [2:0] CK_SUB0 = 3'h4;
  localparam logic [2:0] CK_SUB1 = 3'h5;
  localparam logic [2:0] CK_EXTR = 3'h6;
  localparam logic [2:0] CK_EXTF = 3'h7;
  // divider ratios
  localparam logic [5:0] DIV_SYS4 = 6'h03;
  localparam logic [5:0] DIV_H16 = 6'h0f;
  localparam logic [5:0] DIV_H64 = 6'h3f;
  localparam logic [31:0] PSLVERR_OK = 32'h0000_0000;
endpackage

// File: logic/ptc_clock_gen.sv
// Purpose: one-cycle count enables for every counter clock source
// Assumes: high clock equals system clock; sub clock arrives as enable
// Notes: external pin is taken synchronous to the system clock
`timescale 1ns/1ps
`default_nettype none
module ptc_clock_gen (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst,
  // sources
  input wire logic i_sub_tick,
  input wire logic i_ext_clock_pin,
  input wire logic [2:0] i_clock_sel,
  // result
  output logic o_count_tick
);
  logic [5:0] div_cnt;
  logic ext_prev;
  logic next_tick;

  // free running prescaler, shared by all divided rates
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt <= 6'h00;
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // previous pin level for edge detection
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= i_ext_clock_pin;
    end
  end

  // source decode
  always_comb begin
    case (i_clock_sel)
      ptc_pkg::CK_SYS4: next_tick = (div_cnt[1:0] == ptc_pkg::DIV_SYS4[1:0]);
      ptc_pkg::CK_SYS: next_tick = 1'b1;
      ptc_pkg::CK_H16: next_tick = (div_cnt[3:0] == ptc_pkg::DIV_H16[3:0]);
      ptc_pkg::CK_H64: next_tick = (div_cnt == ptc_pkg::DIV_H64);
      ptc_pkg::CK_SUB0, ptc_pkg::CK_SUB1: next_tick = i_sub_tick;
      ptc_pkg::CK_EXTR: next_tick = i_ext_clock_pin & ~ext_prev;
      ptc_pkg::CK_EXTF: next_tick = ~i_ext_clock_pin & ext_prev;
      default: next_tick = 1'b0;
    endcase
  end

  // registered so the tick lands one cycle after its cause
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_count_tick <= 1'b0;
    end else begin
      o_count_tick <= next_tick;
    end
  end
endmodule
`default_nettype wire

// File: bench/ptc_timer_checker.sv
// Purpose: port-level checks for ptc_timer
// Assumes: apb writes land at the access edge
// Notes: control bytes are shadowed from the apb writes
`timescale 1ns/1ps
`default_nettype none
module ptc_timer_checker (
  // clock, reset and apb
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  // timer outputs
  input wire logic o_timer_out,
  input wire logic o_timer_oe,
  input wire logic [9:0] o_count,
  input wire logic o_capture_pulse
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  logic [7:0] c0;
  logic [7:0] c1;
  logic acc;
  logic rise;
  assign acc = i_psel & i_penable;
  assign rise = acc & i_pwrite & (i_paddr == ptc_pkg::ADDR_CTRL_ZERO) & i_pwdata[3] & !c0[3];
  // shadow copies, so checks need no view inside the block
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      c0 <= 8'h00;
      c1 <= 8'h00;
    end else if (acc & i_pwrite) begin
      if (i_paddr == ptc_pkg::ADDR_CTRL_ZERO) c0 <= i_pwdata[7:0];
      if (i_paddr == ptc_pkg::ADDR_CTRL_ONE) c1 <= i_pwdata[7:0];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  property p_c0_zero;
    acc & !i_pwrite & (i_paddr == ptc_pkg::ADDR_CTRL_ZERO) |-> o_prdata[2:0] == 3'h0;
  endproperty
  a_c0_zero: assert property (p_c0_zero) else $error("low control bits set");
  property p_pause;
    c0[7] [*4] |-> $stable(o_count);
  endproperty
  a_pause: assert property (p_pause) else $error("count moved in pause");
  property p_off;
    !c0[3] [*4] |-> $stable(o_count);
  endproperty
  a_off: assert property (p_off) else $error("count moved while off");
  property p_clear;
    rise |-> ##[1:4] (o_count == 10'h000);
  endproperty
  a_clear: assert property (p_clear) else $error("count not cleared at start");
  property p_init;
    rise & (c1[7:6] == ptc_pkg::MODE_CMP) |-> ##[1:3] (o_timer_out == c1[3]);
  endproperty
  a_init: assert property (p_init) else $error("pin not at initial level");
  property p_tmr;
    (c1[7:6] == ptc_pkg::MODE_TMR) [*3] |-> !o_timer_oe;
  endproperty
  a_tmr: assert property (p_tmr) else $error("pin driven in timer mode");
  property p_oe;
    (c1[7:6] != ptc_pkg::MODE_TMR) [*3] |-> o_timer_oe;
  endproperty
  a_oe: assert property (p_oe) else $error("pin not driven");
  property p_cap;
    o_capture_pulse |-> (c1[7:6] == ptc_pkg::MODE_CAPT) && c0[3];
  endproperty
  a_cap: assert property (p_cap) else $error("capture outside capture mode");
  property p_step;
    (c0[7:3] == 5'h03) [*4] |-> o_count == $past(o_count) + 10'h001;
  endproperty
  a_step: assert property (p_step) else $error("count missed a tick");
  // main scenarios reached
  c_rise: cover property (rise);
  c_cap: cover property (o_capture_pulse);
  c_pause: cover property (c0[7] && c0[3]);
endmodule
bind ptc_timer ptc_timer_checker chk (.i_core_clk(i_core_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_timer_out(o_timer_out),
  .o_timer_oe(o_timer_oe), .o_count(o_count), .o_capture_pulse(o_capture_pulse));
`default_nettype wire

// File: bench/ptc_pin_model.sv
// Purpose: far side pins: sub clock, external clock and capture
// Assumes: ten-cycle base for sub ticks and clock half periods
// Notes: external clock stands still unless the bench runs it
`timescale 1ns/1ps
`default_nettype none
module ptc_pin_model (
  // clock and bench controls
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_ext_run,
  input wire logic i_cap_level,
  // pins toward the timer
  output logic o_sub_tick,
  output logic o_ext_clock_pin,
  output logic o_capture_pin
);
  logic [3:0] div;
  // one base divider keeps both sources at known rates
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      div <= 4'h0;
      o_sub_tick <= 1'b0;
      o_ext_clock_pin <= 1'b0;
    end else begin
      div <= (div == 4'h9) ? 4'h0 : div + 4'h1;
      o_sub_tick <= (div == 4'h9);
      if (i_ext_run && div == 4'h9) o_ext_clock_pin <= !o_ext_clock_pin;
    end
  end
  assign o_capture_pin = i_cap_level;
endmodule
`default_nettype wire

// File: bench/test_periodic_timer_control.sv
// Purpose: self-checking bench for ptc_timer
// Assumes: zero wait state apb slave
// Notes: pin model drives clock sources and capture input
`timescale 1ns/1ps
`default_nettype none
module test_periodic_timer_control;
  logic clk, rst, psel, penable, pwrite, ma, mp, ext_run, cap_lvl;
  logic sub, ext, cap, pready, pslverr, tout, toe, cpul;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, q0, q1;
  logic [9:0] cnt;
  logic [1:0] p;
  int miscompares, total_checks, ncap, ncap0;
  int exp_cnt[8] = '{50, 200, 12, 3, 20, 20, 10, 10};
  ptc_timer uut (.i_core_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_sub_tick(sub), .i_ext_clock_pin(ext),
    .i_capture_pin(cap), .i_match_a(ma), .i_match_p(mp), .o_timer_out(tout),
    .o_timer_oe(toe), .o_count(cnt), .o_capture_pulse(cpul));
  ptc_pin_model pins (.i_core_clk(clk), .i_rst(rst), .i_ext_run(ext_run),
    .i_cap_level(cap_lvl), .o_sub_tick(sub), .o_ext_clock_pin(ext), .o_capture_pin(cap));
  // free-running 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // capture pulses counted per scenario
  always @(posedge clk) begin
    if (cpul === 1'b1) ncap <= ncap + 1;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      miscompares++;
      wrap_up();
    end
    q = prdata;
    check({31'h0, pslverr}, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
  task automatic hit(input logic a);
    ma <= a;
    mp <= !a;
    @(posedge clk);
    ma <= 1'b0;
    mp <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  // off first, so the mode never changes while running
  task automatic setup(input logic [7:0] mode_byte);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h10);
    wr(ptc_pkg::ADDR_CTRL_ONE, {24'h0, mode_byte});
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h18);
    repeat (4) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, psel, penable, pwrite, ma, mp, ext_run, cap_lvl} = 8'h80;
    paddr = 8'h00;
    pwdata = 32'h0;
    miscompares = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(ptc_pkg::ADDR_CTRL_ZERO, q0);
    check(q0, 32'h0);
    rd(ptc_pkg::ADDR_CTRL_ONE, q0);
    check(q0, 32'h0);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'hf7);
    rd(ptc_pkg::ADDR_CTRL_ZERO, q0);
    check(q0, 32'hf0);
    wr(ptc_pkg::ADDR_PERIOD_LOW, 32'ha5);
    wr(ptc_pkg::ADDR_PERIOD_HIGH, 32'hff);
    rd(ptc_pkg::ADDR_PERIOD_LOW, q0);
    check(q0, 32'ha5);
    rd(ptc_pkg::ADDR_PERIOD_HIGH, q0);
    check(q0, 32'h3);
    rd(8'h20, q0);
    check(q0, 32'h0);
    $display("register test done");
    ext_run <= 1'b1;
    for (int s = 0; s < 8; s++) begin
      wr(ptc_pkg::ADDR_CTRL_ZERO, {25'h0, s[2:0], 4'h0});
      wr(ptc_pkg::ADDR_CTRL_ZERO, {25'h0, s[2:0], 4'h8});
      repeat (200) @(posedge clk);
      rd(ptc_pkg::ADDR_CMP_A, q0);
      check(32'(q0 + 5 > exp_cnt[s] && q0 < exp_cnt[s] + 5), 32'h1);
    end
    ext_run <= 1'b0;
    $display("clock select test done");
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h18);
    repeat (20) @(posedge clk);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h98);
    rd(ptc_pkg::ADDR_CMP_A, q0);
    repeat (30) @(posedge clk);
    rd(ptc_pkg::ADDR_CMP_A, q1);
    check(q1, q0);
    check({22'h0, cnt}, q0);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h18);
    repeat (30) @(posedge clk);
    rd(ptc_pkg::ADDR_CMP_A, q1);
    check(32'(q1 > q0), 32'h1);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h10);
    rd(ptc_pkg::ADDR_CMP_A, q0);
    repeat (30) @(posedge clk);
    rd(ptc_pkg::ADDR_CMP_A, q1);
    check(q1, q0);
    check({22'h0, cnt}, q1);
    wr(ptc_pkg::ADDR_CTRL_ZERO, 32'h18);
    rd(ptc_pkg::ADDR_CMP_A, q1);
    check(32'(q1 < 8 && q1 < q0), 32'h1);
    $display("pause and on/off test done");
    for (int k = 0; k < 8; k++) begin
      setup({2'h0, k[2:1], k[0], 3'h0});
      check({31'h0, tout}, {31'h0, k[0]});
      check({31'h0, toe}, 32'h1);
      hit(1'b1);
      p = k[2:1];
      check({31'h0, tout}, {31'h0, p == 2'h0 ? k[0] : p == 2'h3 ? !k[0] : p[1]});
    end
    for (int k = 0; k < 4; k++) begin
      setup({2'h2, k[1:0], 4'h8});
      hit(1'b0);
      check({31'h0, tout}, {31'h0, k != 0});
      hit(1'b1);
      check({31'h0, tout}, {31'h0, k == 1});
    end
    setup(8'hc0);
    check({31'h0, toe}, 32'h0);
    $display("output mode test done");
    // last pass uses a clear setting other than 00: no capture then
    for (int k = 0; k < 5; k++) begin
      if (k == 4) begin
        wr(ptc_pkg::ADDR_CAPT_CFG, 32'h1);
      end
      setup({2'h1, k[1:0], 4'h0});
      ncap0 = ncap;
      cap_lvl <= 1'b1;
      repeat (8) @(posedge clk);
      cap_lvl <= 1'b0;
      repeat (8) @(posedge clk);
      check(32'(ncap - ncap0), k == 2 ? 32'h2 : k < 2 ? 32'h1 : 32'h0);
      rd(ptc_pkg::ADDR_CAPT_STAT, q0);
      check(q0, {15'h0, k < 3, 6'h0, 10'(k == 0 ? 4 : 12)});
    end
    $display("capture test done");
    wrap_up();
  end
endmodule
`default_nettype wire
